// file: core/dcx_defines.vh
// Offsets, field positions, reset values and timing counts of the comm front end
`ifndef DCX_DEFINES_VH
`define DCX_DEFINES_VH

// Parameter indices within the communication group
`define DCX_IDX_REPLY_DELAY    8'h09
`define DCX_IDX_COMM_FREQ      8'h0A
`define DCX_IDX_SLOT_FIRST     8'h0B
`define DCX_IDX_SLOT_LAST      8'h1A
`define DCX_IDX_DECODE_SEL     8'h1E
`define DCX_IDX_PROTO_SEL      8'h1F
`define DCX_IDX_PRESCAN_ZERO   8'h21
`define DCX_IDX_CTRL_ADDR      8'h23
`define DCX_IDX_NODE_ADDR      8'h24
`define DCX_IDX_BIT_RATE       8'h25
`define DCX_IDX_WARN_REC       8'h27
`define DCX_IDX_PROFILE_SEL    8'h28
`define DCX_IDX_NODE_STATE     8'h29

// Reset values and legal limits
`define DCX_RST_REPLY_DELAY    16'h0014
`define DCX_MAX_REPLY_DELAY    16'h07D0
`define DCX_RST_COMM_FREQ      16'h1770
`define DCX_MAX_COMM_FREQ      16'hEA60
`define DCX_RST_SLOT0          16'h010C
`define DCX_RST_SLOT1          16'h010D
`define DCX_RST_SLOT2          16'h010A
`define DCX_RST_SLOT3          16'h010B
`define DCX_RST_SLOT_REST      16'h0000
`define DCX_RST_DECODE_SEL     16'h0001
`define DCX_RST_PROTO_SEL      16'h0000
`define DCX_RST_PRESCAN_ZERO   16'h0001
`define DCX_RST_CTRL_ADDR      16'h0002
`define DCX_MAX_CTRL_ADDR      16'h00FE
`define DCX_MAX_NODE_ADDR      16'h007F
`define DCX_MAX_BIT_RATE       16'h0005
`define DCX_RST_PROFILE_SEL    16'h0001
`define DCX_WARN_MASK          16'h077F

// Prescan clear bits
`define DCX_PZ_FREQ_BIT        0
`define DCX_PZ_TORQUE_BIT      1
`define DCX_PZ_SPDLIM_BIT      2

// Protocol select codes (two's complement)
`define DCX_PROTO_MODBUS       16'h0000
`define DCX_PROTO_BACNET       16'h0001
`define DCX_PROTO_SLAVE8       16'hFFF8
`define DCX_PROTO_RSVD9        16'hFFF7
`define DCX_PROTO_MASTER       16'hFFF6
`define DCX_PROTO_RSVD11       16'hFFF5
`define DCX_PROTO_PLC          16'hFFF4

// Control address bases per decoding method
`define DCX_CTRL_BASE_M1       16'h2000
`define DCX_CTRL_BASE_M2       16'h6000
`define DCX_CAN_INDEX_M1       16'h2020
`define DCX_CAN_INDEX_M2       16'h2060

// Exception codes and reply framing
`define DCX_EXC_VALUE          8'h01
`define DCX_EXC_ADDR           8'h02
`define DCX_EXC_LOCKED         8'h03
`define DCX_EXC_RUNNING        8'h04
`define DCX_EXC_TIMEOUT        8'h0A
`define DCX_FUNC_EXC_FLAG      8'h80
`define DCX_CRC_INIT           16'hFFFF
`define DCX_CRC_POLY           16'hA001

// Delay unit is 0.1 ms; clock period 8 ns
`define DCX_DELAY_UNIT_NS      100000
`define DCX_CLK_PERIOD_NS      8
`define DCX_DELAY_TICK_CYC     (`DCX_DELAY_UNIT_NS / `DCX_CLK_PERIOD_NS)

`endif

// file: core/dcx_core.v
// Exception replies, reply delay and communication parameter group of the drive
`include "dcx_defines.vh"

// Overview of operation
// - corrupted request dropped, no reply sent
// - exception reply sets function code top bit
// - keypad shows exception code as decimal suffix
// - bad value code 1, bad address code 2
// - locked 3, running 4, timeout 10
// - programmable reply delay, 0.0-200.0 ms
// - comm frequency retained through power loss
// - sixteen block transfer slots with defaults
// - decoding method picks serial control range
// - decoding method picks fieldbus control index
// - keypad, terminals, PLC ignore decoding method
// - protocol select sets serial port function
// - prescan bits zero PLC targets
// - sticky fieldbus warning word per event
// - profile select: vendor map or DS402
// - read-only fieldbus network state
module dcx_core #(
  parameter DELAY_TICK_CYCLES = `DCX_DELAY_TICK_CYC,  // Cycles per 0.1 ms
  parameter NUM_SLOTS         = 16                    // Block transfer slots
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  // Parameter access port
  input  wire        par_wr_i,
  input  wire        par_rd_i,
  input  wire [7:0]  par_idx_i,
  input  wire [15:0] par_wdata_i,
  output reg  [15:0] par_rdata_o,
  output reg         par_ack_o,
  output reg         par_err_o,
  // Decoded request from the frame receiver
  input  wire        req_valid_i,
  input  wire        req_comm_err_i,
  input  wire [7:0]  req_slave_i,
  input  wire [7:0]  req_func_i,
  input  wire        req_bad_value_i,
  input  wire        req_bad_addr_i,
  input  wire        req_write_i,
  input  wire        req_run_fixed_i,
  input  wire        req_timeout_i,
  input  wire        params_locked_i,
  input  wire        drive_running_i,
  input  wire        ascii_mode_i,
  output reg         req_busy_o,
  // Reply side
  output reg         rsp_normal_o,
  output reg         rsp_valid_o,
  output reg  [7:0]  rsp_byte_o,
  output reg         rsp_last_o,
  input  wire        rsp_ready_i,
  // Keypad fault text, two BCD digits
  output reg         keypad_comm_fault_show_o,
  output reg  [7:0]  keypad_comm_fault_text_o,
  // Frequency command and retention
  input  wire        freq_src_comm_i,
  input  wire        cmd_freq_valid_i,
  input  wire [15:0] cmd_freq_i,
  input  wire        power_loss_i,
  input  wire        nv_restore_i,
  input  wire [15:0] nv_freq_i,
  output reg         nv_store_o,
  output reg  [15:0] freq_cmd_o,
  // Block transfer slot lookup
  input  wire [3:0]  slot_sel_i,
  output reg  [15:0] slot_ref_o,
  // Decoding, protocol and fieldbus settings
  output reg  [15:0] ctrl_base_o,
  output reg  [15:0] can_ctrl_index_o,
  output reg         proto_modbus_o,
  output reg         proto_bacnet_o,
  output reg  [3:0]  proto_slave_num_o,
  output reg         proto_master_o,
  output reg         proto_plc_o,
  output reg  [7:0]  ctrl_addr_o,
  output reg  [6:0]  node_addr_o,
  output reg  [2:0]  bit_rate_o,
  output reg         can_ds402_o,
  // PLC prescan clears
  input  wire        plc_scan_start_i,
  output reg         plc_zero_freq_o,
  output reg         plc_zero_torque_o,
  output reg         plc_zero_spdlim_o,
  // Fieldbus warning events and state
  input  wire [10:0] can_warn_evt_i,
  input  wire        can_warn_clear_i,
  input  wire [2:0]  can_state_i
);

  // Reply sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_SEND = 2'd2;
  localparam [15:0] CTRL_ADDR_RST = `DCX_RST_CTRL_ADDR;  // Wide default, low byte used

  reg [15:0] delay_q;              // Reply delay, 0.1 ms units
  reg [15:0] slot_q [0:NUM_SLOTS-1];  // Block transfer references
  reg [15:0] decode_q;             // Decoding method select
  reg [15:0] proto_q;              // Protocol select, signed
  reg [15:0] pzero_q;              // Prescan clear bits
  reg [15:0] warn_q;               // Sticky warning word
  reg [15:0] profile_q;            // Fieldbus profile select
  reg [15:0] freq_keep_q;          // Retained comm frequency
  reg [1:0]  state_q;              // Reply sequencer state
  reg        exc_q;                // Reply is an exception
  reg [7:0]  slave_q;              // Captured slave address
  reg [7:0]  func_q;               // Captured function code
  reg [7:0]  code_q;               // Captured exception code
  reg [15:0] units_q;              // Remaining delay units
  reg [15:0] tick_q;               // Cycles within one unit
  reg [2:0]  bidx_q;               // Byte index of the reply
  reg [15:0] crc_q;                // Running frame CRC
  reg [7:0]  lrc_q;                // Running byte sum
  reg [7:0]  exc_code;             // Decoded exception code
  reg        wr_ok;                // Write value within range
  reg        idx_known;            // Index maps to a register
  reg [15:0] rd_val;               // Read mux value
  reg [15:0] crc_nxt;              // CRC after current byte
  reg [7:0]  lrc_nxt;              // Sum after current byte
  reg [7:0]  next_byte;            // Byte that follows the current
  wire       slot_hit;             // Index in slot window
  wire [3:0] slot_idx;             // Slot number from index
  wire [7:0] slot_off;             // Offset into slot window

  assign slot_hit = (par_idx_i >= `DCX_IDX_SLOT_FIRST) && (par_idx_i <= `DCX_IDX_SLOT_LAST);
  assign slot_off = par_idx_i - `DCX_IDX_SLOT_FIRST;
  assign slot_idx = slot_off[3:0];

  // One CRC-16 byte step, reflected polynomial
  function [15:0] crc_step;
    input [15:0] crc_in;
    input [7:0]  data;
    integer      k;
    reg   [15:0] c;
    begin
      c = crc_in ^ {8'h00, data};
      for (k = 0; k < 8; k = k + 1) begin
        if (c[0]) begin
          c = (c >> 1) ^ `DCX_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_step = c;
    end
  endfunction

  // Exception priority: address, value, lock, running, timeout
  always @* begin
    if (req_bad_addr_i) begin
      exc_code = `DCX_EXC_ADDR;
    end else if (req_bad_value_i) begin
      exc_code = `DCX_EXC_VALUE;
    end else if (req_write_i && params_locked_i) begin
      exc_code = `DCX_EXC_LOCKED;
    end else if (req_write_i && drive_running_i && req_run_fixed_i) begin
      exc_code = `DCX_EXC_RUNNING;
    end else if (req_timeout_i) begin
      exc_code = `DCX_EXC_TIMEOUT;
    end else begin
      exc_code = 8'h00;
    end
  end

  // Range check per index; out-of-range writes are refused
  always @* begin
    idx_known = 1'b1;
    wr_ok     = 1'b1;
    if (par_idx_i == `DCX_IDX_REPLY_DELAY) begin
      wr_ok = (par_wdata_i <= `DCX_MAX_REPLY_DELAY);
    end else if (par_idx_i == `DCX_IDX_COMM_FREQ) begin
      wr_ok = (par_wdata_i <= `DCX_MAX_COMM_FREQ);
    end else if (slot_hit) begin
      wr_ok = 1'b1;
    end else if (par_idx_i == `DCX_IDX_DECODE_SEL || par_idx_i == `DCX_IDX_PROFILE_SEL) begin
      wr_ok = (par_wdata_i[15:1] == 15'h0000);
    end else if (par_idx_i == `DCX_IDX_PROTO_SEL) begin
      // Reserved codes and anything outside the table are refused
      wr_ok = (par_wdata_i == `DCX_PROTO_MODBUS) || (par_wdata_i == `DCX_PROTO_BACNET) ||
              ((par_wdata_i >= `DCX_PROTO_SLAVE8) && (par_wdata_i != `DCX_PROTO_RSVD9)) ||
              (par_wdata_i == `DCX_PROTO_MASTER) || (par_wdata_i == `DCX_PROTO_PLC);
    end else if (par_idx_i == `DCX_IDX_PRESCAN_ZERO) begin
      wr_ok = (par_wdata_i[15:3] == 13'h0000);
    end else if (par_idx_i == `DCX_IDX_CTRL_ADDR) begin
      wr_ok = (par_wdata_i != 16'h0000) && (par_wdata_i <= `DCX_MAX_CTRL_ADDR);
    end else if (par_idx_i == `DCX_IDX_NODE_ADDR) begin
      wr_ok = (par_wdata_i <= `DCX_MAX_NODE_ADDR);
    end else if (par_idx_i == `DCX_IDX_BIT_RATE) begin
      wr_ok = (par_wdata_i <= `DCX_MAX_BIT_RATE);
    end else if (par_idx_i == `DCX_IDX_WARN_REC || par_idx_i == `DCX_IDX_NODE_STATE) begin
      wr_ok = 1'b0;                   // Read-only entries
    end else begin
      idx_known = 1'b0;
      wr_ok     = 1'b0;
    end
  end

  // Read mux
  always @* begin
    if (par_idx_i == `DCX_IDX_REPLY_DELAY) begin
      rd_val = delay_q;
    end else if (par_idx_i == `DCX_IDX_COMM_FREQ) begin
      rd_val = freq_keep_q;
    end else if (slot_hit) begin
      rd_val = slot_q[slot_idx];
    end else if (par_idx_i == `DCX_IDX_DECODE_SEL) begin
      rd_val = decode_q;
    end else if (par_idx_i == `DCX_IDX_PROTO_SEL) begin
      rd_val = proto_q;
    end else if (par_idx_i == `DCX_IDX_PRESCAN_ZERO) begin
      rd_val = pzero_q;
    end else if (par_idx_i == `DCX_IDX_CTRL_ADDR) begin
      rd_val = {8'h00, ctrl_addr_o};
    end else if (par_idx_i == `DCX_IDX_NODE_ADDR) begin
      rd_val = {9'h000, node_addr_o};
    end else if (par_idx_i == `DCX_IDX_BIT_RATE) begin
      rd_val = {13'h0000, bit_rate_o};
    end else if (par_idx_i == `DCX_IDX_WARN_REC) begin
      rd_val = warn_q;
    end else if (par_idx_i == `DCX_IDX_PROFILE_SEL) begin
      rd_val = profile_q;
    end else if (par_idx_i == `DCX_IDX_NODE_STATE) begin
      rd_val = {13'h0000, can_state_i};
    end else begin
      rd_val = 16'h0000;
    end
  end

  // Block transfer slots; slots 0-3 have their own defaults, the rest reset to zero
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
      wire [15:0] rst_val;
      assign rst_val = (g == 0) ? `DCX_RST_SLOT0 : (g == 1) ? `DCX_RST_SLOT1 :
                       (g == 2) ? `DCX_RST_SLOT2 : (g == 3) ? `DCX_RST_SLOT3 :
                       `DCX_RST_SLOT_REST;
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          slot_q[g] <= rst_val;
        end else if (clk_en_i && par_wr_i && slot_hit && slot_idx == g) begin
          slot_q[g] <= par_wdata_i;
        end
      end
    end
  endgenerate

  // Settings registers and parameter access answers
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      delay_q     <= `DCX_RST_REPLY_DELAY;
      decode_q    <= `DCX_RST_DECODE_SEL;
      proto_q     <= `DCX_RST_PROTO_SEL;
      pzero_q     <= `DCX_RST_PRESCAN_ZERO;
      ctrl_addr_o <= CTRL_ADDR_RST[7:0];
      node_addr_o <= 7'h00;
      bit_rate_o  <= 3'h0;
      profile_q   <= `DCX_RST_PROFILE_SEL;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
      par_rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      par_ack_o <= par_wr_i | par_rd_i;
      // Error on unknown index, or on a write that was refused
      par_err_o <= (par_rd_i & ~idx_known) | (par_wr_i & ~wr_ok);
      if (par_rd_i) begin
        par_rdata_o <= rd_val;
      end
      if (par_wr_i && wr_ok) begin
        if (par_idx_i == `DCX_IDX_REPLY_DELAY) begin
          delay_q <= par_wdata_i;
        end else if (par_idx_i == `DCX_IDX_DECODE_SEL) begin
          decode_q <= par_wdata_i;
        end else if (par_idx_i == `DCX_IDX_PROTO_SEL) begin
          proto_q <= par_wdata_i;
        end else if (par_idx_i == `DCX_IDX_PRESCAN_ZERO) begin
          pzero_q <= par_wdata_i;
        end else if (par_idx_i == `DCX_IDX_CTRL_ADDR) begin
          ctrl_addr_o <= par_wdata_i[7:0];
        end else if (par_idx_i == `DCX_IDX_NODE_ADDR) begin
          node_addr_o <= par_wdata_i[6:0];
        end else if (par_idx_i == `DCX_IDX_BIT_RATE) begin
          bit_rate_o <= par_wdata_i[2:0];
        end else if (par_idx_i == `DCX_IDX_PROFILE_SEL) begin
          profile_q <= par_wdata_i;
        end
      end
    end
  end

  // Decoded settings, registered so every output is a flop
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_base_o       <= `DCX_CTRL_BASE_M2;
      can_ctrl_index_o  <= `DCX_CAN_INDEX_M2;
      can_ds402_o       <= 1'b1;
      proto_modbus_o    <= 1'b1;
      proto_bacnet_o    <= 1'b0;
      proto_slave_num_o <= 4'h0;
      proto_master_o    <= 1'b0;
      proto_plc_o       <= 1'b0;
      slot_ref_o        <= 16'h0000;
    end else if (clk_en_i) begin
      // Only serial, card and fieldbus control move; keypad, terminals and
      // PLC never look at these bases
      ctrl_base_o       <= decode_q[0] ? `DCX_CTRL_BASE_M2 : `DCX_CTRL_BASE_M1;
      can_ctrl_index_o  <= decode_q[0] ? `DCX_CAN_INDEX_M2 : `DCX_CAN_INDEX_M1;
      can_ds402_o       <= profile_q[0];
      proto_modbus_o    <= (proto_q == `DCX_PROTO_MODBUS);
      proto_bacnet_o    <= (proto_q == `DCX_PROTO_BACNET);
      proto_master_o    <= (proto_q == `DCX_PROTO_MASTER);
      proto_plc_o       <= (proto_q == `DCX_PROTO_PLC);
      // Slave number is the negated code, 1 to 8
      proto_slave_num_o <= (proto_q >= `DCX_PROTO_SLAVE8) ? (4'h0 - proto_q[3:0]) : 4'h0;
      slot_ref_o        <= slot_q[slot_sel_i];
    end
  end

  // Frequency command with retention across power loss
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      freq_keep_q <= `DCX_RST_COMM_FREQ;
      freq_cmd_o  <= `DCX_RST_COMM_FREQ;
      nv_store_o  <= 1'b0;
    end else if (clk_en_i) begin
      nv_store_o <= 1'b0;
      if (nv_restore_i) begin
        // Boot: stored value drives until a new command
        freq_keep_q <= nv_freq_i;
        freq_cmd_o  <= nv_freq_i;
      end else if (cmd_freq_valid_i) begin
        freq_cmd_o <= cmd_freq_i;
      end else if (par_wr_i && wr_ok && par_idx_i == `DCX_IDX_COMM_FREQ) begin
        freq_keep_q <= par_wdata_i;
        freq_cmd_o  <= par_wdata_i;
      end else if (power_loss_i && freq_src_comm_i) begin
        freq_keep_q <= freq_cmd_o;
        nv_store_o  <= 1'b1;
      end
    end
  end

  // Prescan clears, one pulse per enabled bit
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      plc_zero_freq_o   <= 1'b0;
      plc_zero_torque_o <= 1'b0;
      plc_zero_spdlim_o <= 1'b0;
    end else if (clk_en_i) begin
      plc_zero_freq_o   <= plc_scan_start_i & pzero_q[`DCX_PZ_FREQ_BIT];
      plc_zero_torque_o <= plc_scan_start_i & pzero_q[`DCX_PZ_TORQUE_BIT];
      plc_zero_spdlim_o <= plc_scan_start_i & pzero_q[`DCX_PZ_SPDLIM_BIT];
    end
  end

  // Sticky warnings; a new event beats a clear in the same cycle
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      warn_q <= 16'h0000;
    end else if (clk_en_i) begin
      warn_q <= ((can_warn_clear_i ? 16'h0000 : warn_q) | {5'h00, can_warn_evt_i})
                & `DCX_WARN_MASK;
    end
  end

  // Check and next byte for the exception frame
  always @* begin
    crc_nxt = crc_step(crc_q, rsp_byte_o);
    lrc_nxt = lrc_q + rsp_byte_o;
    if (bidx_q == 3'd0) begin
      next_byte = func_q | `DCX_FUNC_EXC_FLAG;
    end else if (bidx_q == 3'd1) begin
      next_byte = code_q;
    end else if (bidx_q == 3'd2) begin
      // ASCII frames end in the negated sum; binary frames send the CRC low byte here, high byte last
      next_byte = ascii_mode_i ? (8'h00 - lrc_nxt) : crc_nxt[7:0];
    end else begin
      next_byte = crc_q[15:8];
    end
  end

  // Reply sequencer: capture, delay, then release the reply
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q     <= ST_IDLE;
      exc_q       <= 1'b0;
      slave_q     <= 8'h00;
      func_q      <= 8'h00;
      code_q      <= 8'h00;
      units_q     <= 16'h0000;
      tick_q      <= 16'h0000;
      bidx_q      <= 3'd0;
      crc_q       <= `DCX_CRC_INIT;
      lrc_q       <= 8'h00;
      req_busy_o  <= 1'b0;
      rsp_normal_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_byte_o  <= 8'h00;
      rsp_last_o  <= 1'b0;
      keypad_comm_fault_show_o <= 1'b0;
      keypad_comm_fault_text_o <= 8'h00;
    end else if (clk_en_i) begin
      rsp_normal_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Corrupted frames vanish: no state change, no reply
          if (req_valid_i && !req_comm_err_i) begin
            state_q    <= ST_WAIT;
            req_busy_o <= 1'b1;
            slave_q    <= req_slave_i;
            func_q     <= req_func_i;
            code_q     <= exc_code;
            exc_q      <= (exc_code != 8'h00);
            units_q    <= delay_q;
            tick_q     <= 16'h0000;
            if (exc_code != 8'h00) begin
              // Decimal suffix: codes 1-4 and 10 as two BCD digits
              keypad_comm_fault_show_o <= 1'b1;
              keypad_comm_fault_text_o <= (exc_code == `DCX_EXC_TIMEOUT) ? 8'h10 : exc_code;
            end else begin
              keypad_comm_fault_show_o <= 1'b0;
            end
          end
        end
        ST_WAIT: begin
          if (units_q == 16'h0000) begin
            if (exc_q) begin
              state_q     <= ST_SEND;
              rsp_valid_o <= 1'b1;
              rsp_byte_o  <= slave_q;
              rsp_last_o  <= 1'b0;
              bidx_q      <= 3'd0;
              crc_q       <= `DCX_CRC_INIT;
              lrc_q       <= 8'h00;
            end else begin
              // Normal replies are framed elsewhere; release after delay
              state_q      <= ST_IDLE;
              req_busy_o   <= 1'b0;
              rsp_normal_o <= 1'b1;
            end
          end else if (tick_q == DELAY_TICK_CYCLES[15:0] - 16'h0001) begin
            tick_q  <= 16'h0000;
            units_q <= units_q - 16'h0001;
          end else begin
            tick_q <= tick_q + 16'h0001;
          end
        end
        ST_SEND: begin
          if (rsp_ready_i) begin
            if (rsp_last_o) begin
              state_q     <= ST_IDLE;
              req_busy_o  <= 1'b0;
              rsp_valid_o <= 1'b0;
              rsp_last_o  <= 1'b0;
            end else begin
              crc_q      <= crc_nxt;
              lrc_q      <= lrc_nxt;
              bidx_q     <= bidx_q + 3'd1;
              rsp_byte_o <= next_byte;
              rsp_last_o <= (bidx_q == 3'd3) || (ascii_mode_i && bidx_q == 3'd2);
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: tb/dcx_master_model.sv
// Master-side model: takes reply bytes, stalling on every other cycle
module dcx_master_model (
  input  wire       clk_i,
  input  wire       rsp_valid_i,
  input  wire [7:0] rsp_byte_i,
  output logic      rsp_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];  // Reply bytes in arrival order
  initial rsp_ready_o = 1'b0;
  // Ready toggles so every byte after the first of a reply must hold through a stall
  always @(posedge clk_i) begin
    if (rsp_valid_i && rsp_ready_o) rx_q.push_back(rsp_byte_i);
    rsp_ready_o <= ~rsp_ready_o;
  end
endmodule

// file: tb/dcx_core_properties.sv
// Port-level assertions on the comm front end
module dcx_core_properties (
  input wire        clk_i,
  input wire        reset_n_i,
  input wire        clk_en_i,
  input wire        par_wr_i,
  input wire        par_rd_i,
  input wire        par_ack_o,
  input wire        req_valid_i,
  input wire        req_comm_err_i,
  input wire        req_busy_o,
  input wire        rsp_valid_o,
  input wire        rsp_ready_i,
  input wire [7:0]  rsp_byte_o,
  input wire        keypad_comm_fault_show_o,
  input wire [7:0]  keypad_comm_fault_text_o,
  input wire        plc_scan_start_i,
  input wire        plc_zero_freq_o,
  input wire [15:0] ctrl_base_o,
  input wire [15:0] can_ctrl_index_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_req_taken: assert property (req_valid_i && !req_comm_err_i && !req_busy_o && clk_en_i
    |=> req_busy_o) else $error("request not taken");
  a_err_dropped: assert property (req_valid_i && req_comm_err_i && !req_busy_o
    |=> !req_busy_o) else $error("corrupted request taken");
  a_ack_timing: assert property ((par_wr_i || par_rd_i) && clk_en_i |=> par_ack_o)
    else $error("no ack after strobe");
  a_ack_cause: assert property (par_ack_o |-> $past(par_wr_i || par_rd_i))
    else $error("ack without strobe");
  a_byte_hold: assert property (rsp_valid_o && !rsp_ready_i
    |=> rsp_valid_o && $stable(rsp_byte_o)) else $error("reply byte dropped");
  a_reply_busy: assert property (rsp_valid_o |-> req_busy_o)
    else $error("reply outside pending request");
  a_keypad_code: assert property (keypad_comm_fault_show_o |-> keypad_comm_fault_text_o
    inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h10}) else $error("bad keypad code");
  a_zero_cause: assert property (plc_zero_freq_o |-> $past(plc_scan_start_i))
    else $error("zero pulse without scan");
  a_decode_pair: assert property ((ctrl_base_o == 16'h6000) == (can_ctrl_index_o == 16'h2060))
    else $error("decode outputs disagree");
  c_reply: cover property (rsp_valid_o && rsp_ready_i);
  c_drop: cover property (req_valid_i && req_comm_err_i);
  c_zero: cover property (plc_zero_freq_o);
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the comm front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bq_t[$];
  logic clk_i = 0, reset_n_i = 0, clk_en_i = 1, par_wr_i = 0, par_rd_i = 0, rsp_ready_i;
  logic [7:0] par_idx_i = 0, req_slave_i = 8'h01, req_func_i = 8'h06;
  logic [15:0] par_wdata_i = 0, cmd_freq_i = 0, nv_freq_i = 0;
  logic req_valid_i = 0, req_comm_err_i = 0, req_bad_value_i = 0, req_bad_addr_i = 0;
  logic req_write_i = 0, req_run_fixed_i = 0, req_timeout_i = 0, params_locked_i = 0;
  logic drive_running_i = 0, ascii_mode_i = 0, freq_src_comm_i = 0, cmd_freq_valid_i = 0;
  logic power_loss_i = 0, nv_restore_i = 0, plc_scan_start_i = 0, can_warn_clear_i = 0;
  logic [3:0] slot_sel_i = 4'h1;
  logic [10:0] can_warn_evt_i = 0;
  logic [2:0] can_state_i = 0;
  wire [15:0] par_rdata_o, freq_cmd_o, slot_ref_o, ctrl_base_o, can_ctrl_index_o;
  wire [7:0] rsp_byte_o, keypad_comm_fault_text_o, ctrl_addr_o;
  wire par_ack_o, par_err_o, req_busy_o, rsp_normal_o, rsp_valid_o, rsp_last_o, nv_store_o;
  wire keypad_comm_fault_show_o, proto_modbus_o, proto_bacnet_o, proto_master_o, proto_plc_o;
  wire can_ds402_o, plc_zero_freq_o, plc_zero_torque_o, plc_zero_spdlim_o;
  wire [3:0] proto_slave_num_o;
  wire [6:0] node_addr_o;
  wire [2:0] bit_rate_o;
  int n_errors = 0, checks = 0, lat;
  dcx_core #(.DELAY_TICK_CYCLES(4)) dcx_core_i (.*);
  dcx_master_model dcx_master_model_i (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
    .rsp_byte_i(rsp_byte_o), .rsp_ready_o(rsp_ready_i));
  task automatic cmp(input string nm, input logic [15:0] ex, got);
    checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  // One parameter access, answer sampled one edge after the strobe
  task automatic par(input logic wr, input logic [7:0] idx, input logic [15:0] d, ex,
    input logic er);
    par_wr_i = wr;
    par_rd_i = !wr;
    par_idx_i = idx;
    par_wdata_i = d;
    @(negedge clk_i);
    par_wr_i = 0;
    par_rd_i = 0;
    cmp("ack", 16'h0001, {15'h0, par_ack_o});
    cmp("err", {15'h0, er}, {15'h0, par_err_o});
    if (!wr) cmp("rdata", ex, par_rdata_o);
    @(negedge clk_i);
  endtask
  // One request, then the reply bytes against the expected frame
  task automatic req(input logic ce, ba, tmo, input bq_t e);
    int n;
    dcx_master_model_i.rx_q.delete();
    lat = -1;
    {req_comm_err_i, req_bad_addr_i, req_timeout_i} = {ce, ba, tmo};
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
    cmp("busy", {15'h0, !ce}, {15'h0, req_busy_o});
    for (n = 0; n < 400 && req_busy_o === 1'b1; n++) begin
      if (rsp_valid_o === 1'b1 && lat < 0) lat = n;
      @(negedge clk_i);
    end
    cmp("done", 16'h0000, {15'h0, req_busy_o});
    cmp("count", 16'(e.size()), 16'(dcx_master_model_i.rx_q.size()));
    foreach (e[i]) cmp("byte", {8'h0, e[i]}, {8'h0, dcx_master_model_i.rx_q[i]});
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #4 clk_i = ~clk_i;
  // Hang guard, far above the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    reset_n_i = 1;
    par(0, 8'h09, 0, 16'h0014, 0);
    par(0, 8'h0a, 0, 16'h1770, 0);
    par(0, 8'h0b, 0, 16'h010c, 0);
    par(0, 8'h1a, 0, 16'h0000, 0);
    par(0, 8'h1e, 0, 16'h0001, 0);
    par(0, 8'h27, 0, 16'h0000, 0);
    par(1, 8'h27, 16'h0001, 0, 1);
    par(1, 8'h09, 16'h07d1, 0, 1);
    par(1, 8'h09, 16'h0000, 0, 0);
    cmp("slot", 16'h010d, slot_ref_o);
    req(1, 0, 0, '{});
    req(0, 1, 0, '{8'h01, 8'h86, 8'h02, 8'hc3, 8'ha1});
    cmp("keypad", 16'h0002, {8'h0, keypad_comm_fault_text_o});
    ascii_mode_i = 1;
    req(0, 0, 1, '{8'h01, 8'h86, 8'h0a, 8'h6f});
    cmp("keypad", 16'h0010, {8'h0, keypad_comm_fault_text_o});
    ascii_mode_i = 0;
    par(1, 8'h09, 16'h0002, 0, 0);
    req(0, 1, 0, '{8'h01, 8'h86, 8'h02, 8'hc3, 8'ha1});
    cmp("delay", 16'h0009, 16'(lat));
    par(1, 8'h1e, 16'h0000, 0, 0);
    cmp("base", 16'h2000, ctrl_base_o);
    cmp("index", 16'h2020, can_ctrl_index_o);
    par(1, 8'h1f, 16'hfff7, 0, 1);
    par(1, 8'h1f, 16'hfffd, 0, 0);
    cmp("slave", 16'h0003, {12'h0, proto_slave_num_o});
    par(1, 8'h28, 16'h0000, 0, 0);
    cmp("ds402", 16'h0000, {15'h0, can_ds402_o});
    {can_warn_clear_i, can_state_i, can_warn_evt_i} = {1'b1, 3'h5, 11'h7ff};
    @(negedge clk_i);
    {can_warn_clear_i, can_warn_evt_i} = 0;
    par(0, 8'h27, 0, 16'h077f, 0);
    par(0, 8'h29, 0, 16'h0005, 0);
    {freq_src_comm_i, cmd_freq_valid_i, cmd_freq_i} = {2'b11, 16'h1234};
    @(negedge clk_i);
    {cmd_freq_valid_i, power_loss_i} = 2'b01;
    @(negedge clk_i);
    power_loss_i = 0;
    cmp("store", 16'h0001, {15'h0, nv_store_o});
    par(0, 8'h0a, 0, 16'h1234, 0);
    par(1, 8'h21, 16'h0005, 0, 0);
    plc_scan_start_i = 1;
    @(negedge clk_i);
    plc_scan_start_i = 0;
    cmp("zero", 16'h0005, {13'h0, plc_zero_spdlim_o, plc_zero_torque_o, plc_zero_freq_o});
    stop_test();
  end
endmodule
bind dcx_core dcx_core_properties dcx_core_properties_i (.*);
